// ---- sim/tb_watchdog_interval_timer.sv ----
// Purpose: Self-checking bench for the watchdog interval timer
// Assumes: Low-speed clock made here, ten system cycles a period
// Notes:   Tick counts allow one tick of synchroniser slack
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_watchdog_interval_timer;
  import wdt_pkg::*;
  localparam logic [7:0] CTL = WATCHDOG_CONTROL_ADDR;
  localparam logic [7:0] CAU = RESET_CAUSE_ADDR;
  logic       sys_clk    = 1'b0;
  logic       nrst       = 1'b0;
  logic       npor       = 1'b0;
  logic       lf_clk     = 1'b0;
  logic [1:0] sleep      = 2'h0;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic       ce         = 1'b1;  // Clock enable
  logic [7:0] rdata;
  logic       wdt_rst;
  logic       irq;
  logic [3:0] lf_div     = 4'h0; // Low-speed divider
  int         ticks      = 0;    // Low-speed rising edges
  int         n_irq      = 0;    // Interrupt pulses seen
  int         n_mismatch = 0;
  int         num_checks = 0;
  watchdog_interval_timer dut (.i_sys_clk(sys_clk), .i_nrst(nrst),
    .i_npor(npor), .i_ce(ce), .i_lf_clk(lf_clk), .i_sleep_mode(sleep),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_wdt_rst(wdt_rst), .o_timer_irq(irq));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Low-speed clock, half period five system cycles
  always @(posedge sys_clk) begin
    lf_div <= (lf_div == 4'h4) ? 4'h0 : lf_div + 4'h1;
    if (lf_div == 4'h4) lf_clk <= ~lf_clk;
  end
  always @(posedge lf_clk) ticks++;
  always @(posedge sys_clk) if (irq === 1'b1) n_irq++;
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(negedge sys_clk);
    `CHK(nm, e, rdata)
  endtask : rchk
  task automatic waitk(input int n);
    repeat (n * 10) @(posedge sys_clk);
  endtask : waitk
  // Wait for expiry, then judge the ticks since t0
  task automatic expire(input int t0, input int per, input bit w,
                        input string nm);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while ((w ? wdt_rst : irq) !== 1'b1 && k < per * 20);
    `CHK(nm, 1'b1, ticks - t0 >= per - 1 && ticks - t0 <= per + 1)
  endtask : expire
  task automatic do_reset();
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset
  task automatic t_reset();
    rchk(CTL, WATCHDOG_CONTROL_RST, "ctl reset");
    rchk(CAU, {6'h00, CAUSE_POWER_ON}, "cause por");
    rchk(8'h00, 8'h00, "unmapped");
    wreg(CAU, 8'hFF);
    rchk(CAU, {6'h00, CAUSE_POWER_ON}, "cause ro");
    $display("test reset done");
  endtask : t_reset
  task automatic t_timer();
    int t0;
    int i0;
    wreg(CTL, 8'h07);
    i0 = n_irq;
    waitk(100);
    `CHK("off irqs", 0, n_irq - i0)
    rchk(CTL, 8'h07, "layout");
    t0 = ticks;
    wreg(CTL, 8'h0F);
    expire(t0, 64, 1'b0, "irq 64");
    expire(ticks, 64, 1'b0, "irq again");
    t0 = ticks;
    wreg(CTL, 8'h1E);
    expire(t0, 512, 1'b0, "irq 512");
    waitk(40);
    t0 = ticks;
    wreg(CTL, 8'h1F);
    expire(t0, 64, 1'b0, "clear");
    waitk(40);
    wreg(CTL, 8'h07);
    i0 = n_irq;
    waitk(100);
    `CHK("stopped", 0, n_irq - i0)
    t0 = ticks;
    wreg(CTL, 8'h0F);
    expire(t0, 64, 1'b0, "restart");
    for (int s = 2; s < 4; s++) begin
      waitk(40);
      sleep <= 2'(s);
      i0 = n_irq;
      waitk(100);
      sleep <= 2'h0;
      `CHK("sleep irqs", 0, n_irq - i0)
      t0 = ticks;
      expire(t0, 64, 1'b0, "after sleep");
    end
    `CHK("timer rst", 1'b0, wdt_rst)
    $display("test timer done");
  endtask : t_timer
  // Enable low for exactly 100 low-speed periods delays the next irq
  task automatic t_freeze();
    int t0;
    t0 = ticks;
    waitk(20);
    ce <= 1'b0;
    waitk(100);
    ce <= 1'b1;
    expire(t0, 164, 1'b0, "ce freeze");
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_wdog();
    int t0;
    int i0;
    do_reset();
    wreg(CTL, 8'h0B);
    i0 = n_irq;
    wreg(CTL, 8'h03);
    wreg(CTL, 8'h0F);
    rchk(CTL, 8'h0B, "locked");
    wreg(CTL, 8'hAA);
    wreg(CTL, 8'h5A);
    rchk(CTL, 8'h5A, "int change");
    repeat (3) begin
      waitk(40);
      wreg(CTL, 8'hAB);
      wreg(CTL, 8'h5B);
    end
    t0 = ticks;
    waitk(20);
    wreg(CTL, 8'hAB);
    wreg(CTL, 8'h3B);
    waitk(20);
    wreg(CTL, 8'hAB);
    repeat (160) @(posedge sys_clk);
    wreg(CTL, 8'h5B);
    expire(t0, 64, 1'b1, "wdt expiry");
    `CHK("wdt irqs", 0, n_irq - i0)
    do_reset();
    rchk(CAU, {6'h00, CAUSE_WATCHDOG}, "cause wdt");
    rchk(CTL, 8'h00, "ctl cleared");
    do_reset();
    rchk(CAU, {6'h00, CAUSE_EXTERNAL}, "cause pin");
    $display("test watchdog done");
  endtask : t_wdog
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    npor <= 1'b1;
    t_reset();
    t_timer();
    t_freeze();
    t_wdog();
    results();
  end
  // Hang guard, about twice the expected run
  initial begin
    #(40000 * 100);
    n_mismatch++;
    results();
  end
endmodule : tb_watchdog_interval_timer
`default_nettype wire

// ---- sim/wdt_sva.sv ----
// Purpose: Port checks for the watchdog interval timer
// Assumes: One clock domain, i_nrst async active low, i_ce high
// Notes:   A shadow of the control register follows bus writes
`timescale 1ns/10ps
`default_nettype none
module wdt_sva
  import wdt_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       i_npor,
  input wire logic       i_ce,
  input wire logic       i_lf_clk,
  input wire logic [1:0] i_sleep_mode,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_wdt_rst,
  input wire logic       o_timer_irq
);
  logic [7:0] sh;   // Expected control contents
  logic       lock; // Enabled in watchdog mode
  logic       cwr;  // Accepted control write
  assign cwr = i_ce && i_wr && i_addr == WATCHDOG_CONTROL_ADDR;
  // Shadow follows writes; enable and mode freeze once locked
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sh   <= 8'h00;
      lock <= 1'b0;
    end else if (cwr) begin
      sh   <= lock ? {i_wdata[7:4], sh[3:2], i_wdata[1:0]} : i_wdata;
      lock <= lock | (i_wdata[3] & ~i_wdata[2]);
    end
  end
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
  a_ctrl_readback: assert property (
    $past(i_rd) && $past(i_addr) == WATCHDOG_CONTROL_ADDR
    |-> o_rdata == $past(sh)) else $error("control readback wrong");
  a_cause_code: assert property (
    $past(i_rd) && $past(i_addr) == RESET_CAUSE_ADDR
    |-> o_rdata[7:2] == 6'h00 && o_rdata[1:0] != 2'h3)
    else $error("bad cause code");
  a_irq_pulse: assert property (
    o_timer_irq |=> !o_timer_irq) else $error("irq longer than one cycle");
  a_rst_hold: assert property (
    o_wdt_rst |=> o_wdt_rst) else $error("reset request dropped");
  a_rst_needs_lock: assert property (
    $rose(o_wdt_rst) |-> lock) else $error("reset outside watchdog mode");
  a_wd_no_irq: assert property (
    lock && $past(lock) |-> !o_timer_irq) else $error("irq in watchdog mode");
  a_irq_in_timer: assert property (
    o_timer_irq |-> sh[3:2] == 2'h3 || $past(sh[3:2]) == 2'h3)
    else $error("irq while timer not running");
  a_sleep_quiet: assert property (
    i_sleep_mode[1] [*4] |-> !o_timer_irq && !$rose(o_wdt_rst))
    else $error("expiry during deep sleep");
  c_wd_expire: cover property ($rose(o_wdt_rst));
  c_timer_irq: cover property (o_timer_irq && !lock);
  c_lock_write: cover property (lock && cwr);
endmodule : wdt_sva
bind watchdog_interval_timer wdt_sva u_sva (.i_sys_clk, .i_nrst, .i_npor,
  .i_ce, .i_lf_clk, .i_sleep_mode, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_wdt_rst, .o_timer_irq);
`default_nettype wire

// ---- src/key_clear_seq.sv ----
// Purpose: Detect the two-write watchdog clear key sequence
// Assumes: Key writes already qualified by enable and watchdog mode
// Notes:   Second key must land within half a low-speed period

`timescale 1ns/10ps
`default_nettype none

module key_clear_seq
  import wdt_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire logic       i_key_wr,
  input  wire logic [3:0] i_key,
  output logic            o_clear
);

  // Sequence states
  typedef enum logic {
    SEQ_IDLE  = 1'b0,
    SEQ_ARMED = 1'b1
  } seq_st_t;

  typedef struct packed {
    seq_st_t    st;
    logic [7:0] left;
    logic       clear;
  } seq_state_t;

  seq_state_t cur;       // Registered state
  seq_state_t next_cur;  // Next state

  // Arm on first key, fire on second key in time
  always_comb begin
    next_cur       = cur;
    next_cur.clear = 1'b0;
    case (cur.st)
      SEQ_IDLE: begin
        if (i_key_wr && i_key == KEY_FIRST) begin
          next_cur.st   = SEQ_ARMED;
          next_cur.left = KEY_WINDOW_CYC;
        end
      end
      SEQ_ARMED: begin
        if (i_key_wr) begin
          // Any other value drops the sequence; 0xA re-arms
          next_cur.clear = (i_key == KEY_SECOND);
          next_cur.st    = (i_key == KEY_FIRST) ? SEQ_ARMED : SEQ_IDLE;
          next_cur.left  = KEY_WINDOW_CYC;
        end else if (cur.left == 8'h01) begin
          next_cur.st = SEQ_IDLE;
        end else begin
          next_cur.left = cur.left - 8'h01;
        end
      end
      default: next_cur.st = SEQ_IDLE;
    endcase
  end

  // State register, frozen by clock enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  assign o_clear = cur.clear;

endmodule : key_clear_seq

`default_nettype wire

// ---- src/lf_tick_sync.sv ----
// Purpose: Turn the low-speed clock input into one-cycle ticks
// Assumes: Low-speed clock far slower than the system clock
// Notes:   First flop feeds only the second flop

`timescale 1ns/10ps
`default_nettype none

module lf_tick_sync
  import wdt_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_lf_clk,
  output logic      o_tick
);

  // Synchroniser and edge history
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic [1:0] fill;  // Cycles since reset, saturating
  } tick_state_t;

  tick_state_t cur;       // Registered state
  tick_state_t next_cur;  // Next state

  // Shift the input through the synchroniser
  always_comb begin
    next_cur      = cur;
    next_cur.meta = i_lf_clk;
    next_cur.sync = cur.meta;
    next_cur.prev = cur.sync;
    // History is only real once prev holds a sampled pin level
    next_cur.fill = (cur.fill == 2'h3) ? cur.fill : cur.fill + 2'h1;
  end

  // State register, frozen by clock enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  // Rising edge of the low-speed clock, none from the reset value
  assign o_tick = i_ce & (cur.fill == 2'h3) & cur.sync & ~cur.prev;

endmodule : lf_tick_sync

`default_nettype wire

// ---- src/watchdog_interval_timer.sv ----
// Purpose: Watchdog and interval timer with one control register
// Assumes: Plain register port, 10 MHz clock, low-speed clock as input
// Notes:   Reset cause survives i_nrst and is cleared by i_npor only
//
// How it works
// - 15-bit counter advances on low-speed clock ticks
// - Deep sleep levels force counter to zero
// - Reset leaves control all zero, timer off
// - Mode bit: 0 watchdog, 1 interval timer
// - Enable bit set starts counting each tick
// - Watchdog running ignores enable clear writes
// - Watchdog running ignores mode bit writes
// - Interval codes pick 32768, 8192, 512, 64
// - Watchdog expiry requests a system reset
// - Keys 0xA then 0x5 quickly clear watchdog
// - Sequence clears only if the second key lands in the window
// - Key writes ignored while enable is zero
// - Interval select stays writable while running
// - Watchdog mode never raises an interrupt
// - Timer mode expiry raises an interrupt pulse
// - Timer mode expiry never resets the system
// - Timer mode key bit 0 clears counter
// - Timer disable stops, re-enable restarts from zero
// - Control layout: key, enable, mode, interval
// - Reset cause readable after every reset
// - Cause codes: 00 power, 01 pin, 10 watchdog
//
// The plain strobed port is this design's own decision.

`timescale 1ns/10ps
`default_nettype none

module watchdog_interval_timer
  import wdt_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_npor,
  input  wire logic       i_ce,
  input  wire logic       i_lf_clk,
  input  wire logic [1:0] i_sleep_mode,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_wdt_rst,
  output logic            o_timer_irq
);

  // Timer state, cleared by system reset
  typedef struct packed {
    watchdog_control_t ctrl;     // Control register
    logic [14:0]       count;    // Interval counter
    logic              rst_req;  // Watchdog reset request
    logic              irq;      // Interval interrupt pulse
    logic [7:0]        rdata;    // Read data, one cycle after strobe
  } timer_state_t;

  // Reset cause state, cleared by power-on reset only
  typedef struct packed {
    logic       nrst_meta;  // Reset pin synchroniser, first stage
    logic       nrst_sync;  // Reset pin synchroniser, second stage
    logic       nrst_prev;  // Previous synchronised level
    logic       pending;    // Watchdog asked for the reset
    logic [1:0] cause;      // Latest reset cause
  } cause_state_t;

  timer_state_t cur;         // Registered timer state
  timer_state_t next_cur;    // Next timer state
  cause_state_t cause;       // Registered cause state
  cause_state_t next_cause;  // Next cause state

  logic              lf_tick;      // One cycle per low-speed rising edge
  logic              key_clear;    // Completed watchdog key sequence
  logic              ctrl_wr;      // Write to control register
  logic              ctrl_rd;      // Read of control register
  logic              cause_rd;     // Read of reset cause register
  logic              wd_locked;    // Watchdog running, locked on
  logic              key_wr;       // Qualified watchdog key write
  watchdog_control_t wr_ctrl;      // Written value as fields
  logic              deep_sleep;   // Sleep level two or three
  logic              restart;      // Enable rising, count from zero
  logic              timer_clear;  // Timer mode direct clear
  logic              at_last;      // Counter at selected interval end

  // Register port decode
  always_comb begin
    ctrl_wr  = 1'b0;
    ctrl_rd  = 1'b0;
    cause_rd = 1'b0;
    if (i_addr == WATCHDOG_CONTROL_ADDR) begin
      ctrl_wr = i_wr;
      ctrl_rd = i_rd;
    end else if (i_addr == RESET_CAUSE_ADDR) begin
      cause_rd = i_rd;
    end
  end

  // Written byte viewed through the field layout
  assign wr_ctrl = watchdog_control_t'(i_wdata);

  // Enabled in watchdog mode locks enable and mode
  assign wd_locked = cur.ctrl.en && (cur.ctrl.mode == MODE_WATCHDOG);

  // Key writes count only while enabled in watchdog mode
  assign key_wr = ctrl_wr && wd_locked;

  // Counter wipe when the chip goes to deep sleep
  assign deep_sleep = (i_sleep_mode == SLEEP_LEVEL_TWO) ||
                      (i_sleep_mode == SLEEP_LEVEL_THREE);

  // Off to on through a write restarts the count
  assign restart = ctrl_wr && !cur.ctrl.en && wr_ctrl.en;

  // Timer mode clear by key bit 0, only while enabled
  assign timer_clear = ctrl_wr && cur.ctrl.en &&
                       (cur.ctrl.mode == MODE_TIMER) &&
                       wr_ctrl.clear_key_field[0];

  // Terminal count for the selected interval
  assign at_last = (cur.count ==
                    interval_last(cur.ctrl.interval_select));

  // Low-speed clock edges brought into this domain
  lf_tick_sync u_tick (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_lf_clk  (i_lf_clk),
    .o_tick    (lf_tick)
  );

  // Two-write clear key detection
  key_clear_seq u_key (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_key_wr  (key_wr),
    .i_key     (wr_ctrl.clear_key_field),
    .o_clear   (key_clear)
  );

  // Control register, counter and expiry handling
  always_comb begin
    next_cur       = cur;
    next_cur.irq   = 1'b0;
    next_cur.rdata = 8'h00;

    // Control register write
    if (ctrl_wr) begin
      // Interval and key always take the new value
      next_cur.ctrl.interval_select = wr_ctrl.interval_select;
      next_cur.ctrl.clear_key_field = wr_ctrl.clear_key_field;
      if (!wd_locked) begin
        // Free to change mode and enable
        next_cur.ctrl.mode = wr_ctrl.mode;
        next_cur.ctrl.en   = wr_ctrl.en;
      end
      // Locked: enable and mode keep their value
    end

    // Counter update, sleep wipe first
    if (deep_sleep) begin
      next_cur.count = COUNT_RST;
    end else if (restart || timer_clear) begin
      // Fresh start or direct timer clear
      next_cur.count = COUNT_RST;
    end else if (key_clear && cur.ctrl.en) begin
      // Completed key sequence wins even on the last tick
      next_cur.count = COUNT_RST;
    end else if (cur.ctrl.en && lf_tick && !cur.rst_req) begin
      if (at_last) begin
        if (cur.ctrl.mode == MODE_TIMER) begin
          // Periodic event, no reset
          next_cur.irq   = 1'b1;
          next_cur.count = COUNT_RST;
        end else begin
          // Expiry in watchdog mode, no interrupt
          next_cur.rst_req = 1'b1;
        end
      end else begin
        // Plain increment per low-speed period
        next_cur.count = cur.count + 15'h0001;
      end
    end

    // Read data for the following cycle only
    if (ctrl_rd) begin
      next_cur.rdata = cur.ctrl;
    end else if (cause_rd) begin
      next_cur.rdata = {6'h00, cause.cause};
    end
  end

  // Timer state register, all zero on system reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur.ctrl    <= watchdog_control_t'(WATCHDOG_CONTROL_RST);
      cur.count   <= COUNT_RST;
      cur.rst_req <= 1'b0;
      cur.irq     <= 1'b0;
      cur.rdata   <= 8'h00;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  // Reset cause tracking across system resets
  always_comb begin
    next_cause           = cause;
    next_cause.nrst_meta = i_nrst;
    next_cause.nrst_sync = cause.nrst_meta;
    next_cause.nrst_prev = cause.nrst_sync;
    // Remember that the watchdog asked for a reset
    if (cur.rst_req) begin
      next_cause.pending = 1'b1;
    end
    // Falling edge of the reset pin names the cause
    if (!cause.nrst_sync && cause.nrst_prev) begin
      next_cause.pending = 1'b0;
      if (cause.pending || cur.rst_req) begin
        next_cause.cause = CAUSE_WATCHDOG;
      end else begin
        next_cause.cause = CAUSE_EXTERNAL;
      end
    end
  end

  // Cause register, power-on only clears it
  always_ff @(posedge i_sys_clk or negedge i_npor) begin
    if (!i_npor) begin
      cause.nrst_meta <= 1'b0;
      cause.nrst_sync <= 1'b0;
      cause.nrst_prev <= 1'b0;
      cause.pending   <= 1'b0;
      cause.cause     <= CAUSE_POWER_ON;
    end else if (i_ce) begin
      cause <= next_cause;
    end
  end

  // Outputs straight from flops
  assign o_rdata     = cur.rdata;
  assign o_wdt_rst   = cur.rst_req;
  assign o_timer_irq = cur.irq;

endmodule : watchdog_interval_timer

`default_nettype wire

// ---- src/wdt_pkg.sv ----
// Purpose: Shared constants, types and helpers for the watchdog timer
// Assumes: 10 MHz system clock, 32.768 kHz low-speed clock input
// Notes:   Register offsets, field positions and counts live here only

package wdt_pkg;

  // System and low-speed clock rates
  localparam int unsigned SYS_CLK_HZ   = 10_000_000;
  localparam int unsigned SYS_CLK_MHZ  = 10;
  localparam int unsigned LF_CLK_HZ    = 32_768;

  // Half a low-speed period in ns, rounded down (longest time)
  localparam int unsigned KEY_WINDOW_NS = 1_000_000_000 / (2 * LF_CLK_HZ);
  // The same window in system clock cycles, rounded down
  localparam int unsigned KEY_WINDOW_CYC_I =
    (KEY_WINDOW_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [7:0] KEY_WINDOW_CYC = 8'(KEY_WINDOW_CYC_I);

  // Register offsets
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hC9;
  localparam logic [7:0] RESET_CAUSE_ADDR      = 8'hCA;

  // Control field positions
  localparam int unsigned CTRL_KEY_MSB = 7;
  localparam int unsigned CTRL_KEY_LSB = 4;
  localparam int unsigned CTRL_EN_BIT  = 3;
  localparam int unsigned CTRL_MODE_BIT = 2;
  localparam int unsigned CTRL_INT_MSB = 1;
  localparam int unsigned CTRL_INT_LSB = 0;

  // Reset values
  localparam logic [7:0]  WATCHDOG_CONTROL_RST = 8'h00;
  localparam logic [14:0] COUNT_RST            = 15'h0000;

  // Clear keys
  localparam logic [3:0] KEY_FIRST  = 4'hA;
  localparam logic [3:0] KEY_SECOND = 4'h5;

  // Reset cause codes
  localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
  localparam logic [1:0] CAUSE_EXTERNAL = 2'h1;
  localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;

  // Deep sleep levels that wipe the counter
  localparam logic [1:0] SLEEP_LEVEL_TWO   = 2'h2;
  localparam logic [1:0] SLEEP_LEVEL_THREE = 2'h3;

  // Operating mode
  typedef enum logic {
    MODE_WATCHDOG = 1'b0,
    MODE_TIMER    = 1'b1
  } wdt_mode_t;

  // Control register layout, msb first
  typedef struct packed {
    logic [3:0] clear_key_field;
    logic       en;
    wdt_mode_t  mode;
    logic [1:0] interval_select;
  } watchdog_control_t;

  // Last count value of each interval (period count minus one)
  function automatic logic [14:0] interval_last(input logic [1:0] sel);
    case (sel)
      2'h0:    interval_last = 15'h7FFF;
      2'h1:    interval_last = 15'h1FFF;
      2'h2:    interval_last = 15'h01FF;
      default: interval_last = 15'h003F;
    endcase
  endfunction : interval_last

endpackage : wdt_pkg
